/* File: design/apcl_regs.vh */
// register map, field positions and reset values for the alarm and pin config logic
// Function
// R1: low reset level returns every internal node to its power-on value.
// R2: overtemp alarm pin driven low and latched above 130 C or programmed threshold.
// R3: two overtemp flags, latched holds, live shows still above threshold.
// R4: clear bit 6 written in any channel register releases latched overtemp alarm.
// R5: guard/clamp alarm output stays disabled after reset until enabled.
// R6: control bits enable guard/clamp alarm output and pick latched or live.
// R7: guard and clamp alarm sources separately enabled onto the shared output.
// R8: per channel, per source, one latched and one live status flag.
// R9: interface select pin low picks SPI, high picks LVDS; undriven means SPI.
// R10: in LVDS mode comparator output pins become differential interface pins.
// R11: shared low-sense input is default ground reference for all channels.
// R12: software may switch each channel's guard pin to dedicated low-sense input.
// R13: at power-on pin is guard input; in low-sense use guard takes high sense.
// R14: latched output holds until clear or reset; unlatched follows live condition.
`ifndef APCL_REGS_VH
`define APCL_REGS_VH
`define APCL_SYSCTRL_ADDR 4'h0
`define APCL_CHREG_ADDR 4'h4
`define APCL_TEMPTH_ADDR 4'h8
`define APCL_ALMSTAT_ADDR 4'hC
`define APCL_INTSTAT_ADDR 5'h10
`define APCL_INTMASK_ADDR 5'h14
`define APCL_CLEAR_BIT 6
`define APCL_TEMP_DEFAULT 8'h82
`define APCL_SYS_CGEN 0
`define APCL_SYS_CGLATCH 1
`define APCL_SYS_GUARDEN 2
`define APCL_SYS_CLAMPEN 3
`define APCL_SYS_LSENSE_LSB 4
`define APCL_SYS_THUSE 8
`define APCL_SYSCTRL_RESET 32'h00000000
`endif

/* File: design/apcl_sync.v */
// two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module apcl_sync #(
    parameter W = 1
) (
    input wire aclk,
    input wire aresetn,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] meta_reg;

    // first stage feeds only the second stage
    always @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg <= {W{1'b0}};
            q <= {W{1'b0}};
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule

/* File: design/apcl_top.v */
// alarm and pin configuration logic with an AXI4-Lite register slave
`timescale 1ns/1ps
`include "apcl_regs.vh"
module apcl_top (
    input wire aclk,
    input wire aresetn,
    input wire [4:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [4:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [7:0] junction_temp,
    input wire [3:0] guard_fault,
    input wire [3:0] clamp_fault,
    input wire iface_select,
    output wire overtemp_alarm_n_o,
    output wire overtemp_alarm_n_oe_n,
    output wire guard_clamp_alarm_n_o,
    output wire guard_clamp_alarm_n_oe_n,
    output reg lvds_mode,
    output reg [3:0] comparator_pins_as_lvds,
    output reg [3:0] guard_or_low_sense_sel,
    output reg [3:0] guard_amp_from_high_sense,
    output reg shared_low_sense_in_use,
    output wire irq
);
    // synchronised pin-side inputs
    // every pin input crosses into aclk through two flops before any use
    wire [7:0] temp_s;
    wire [3:0] guard_s;
    wire [3:0] clamp_s;
    wire iface_s;

    apcl_sync #(.W(17)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d({junction_temp, guard_fault, clamp_fault, iface_select}),
        .q({temp_s, guard_s, clamp_s, iface_s})
    );

    // registers
    reg [31:0] sysctrl_reg;
    reg [7:0] temp_th_reg;
    reg [3:0] chreg_reg;
    reg temp_latch_reg;
    reg [3:0] guard_latch_reg;
    reg [3:0] clamp_latch_reg;
    reg [2:0] int_stat_reg;
    reg [2:0] int_mask_reg;
    reg temp_live_d_reg;
    reg [3:0] guard_live_d_reg;
    reg [3:0] clamp_live_d_reg;
    reg aw_hold_reg;
    reg w_hold_reg;
    reg [4:0] aw_addr_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;
    reg [7:0] temp_prev_reg;
    reg [7:0] temp_cur_reg;
    reg cg_oe_n_reg;

    // active threshold: default unless control bit 8 selects the programmed one
    // switching between the two takes effect on the very next compare
    wire [7:0] threshold;
    assign threshold = sysctrl_reg[`APCL_SYS_THUSE] ? temp_th_reg : `APCL_TEMP_DEFAULT; // [R2]

    // temperature word: each bit is synchronised alone, so a change can show a mix of
    // old and new bits for one cycle; a word is taken only when two samples agree
    always @(posedge aclk) begin
        if (!aresetn) begin
            temp_prev_reg <= 8'h00;
            temp_cur_reg <= 8'h00;
        end else begin
            temp_prev_reg <= temp_s;
            if (temp_s == temp_prev_reg) begin
                temp_cur_reg <= temp_s;
            end
        end
    end

    // live conditions; fault pins are one bit per channel, so two flops suffice
    wire temp_live;
    wire [3:0] guard_live;
    wire [3:0] clamp_live;
    assign temp_live = (temp_cur_reg > threshold); // [R3]
    assign guard_live = guard_s;
    assign clamp_live = clamp_s;

    // write channel acceptance; each address and data channel taken independently
    // a pending response blocks both channels, so one write at most is under way
    assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_hold_reg && !s_axi_bvalid;
    wire aw_have;
    wire w_have;
    wire [4:0] wr_addr;
    wire [31:0] wr_data;
    wire [3:0] wr_strb;
    assign aw_have = aw_hold_reg || (s_axi_awvalid && s_axi_awready);
    assign w_have = w_hold_reg || (s_axi_wvalid && s_axi_wready);
    assign wr_addr = aw_hold_reg ? aw_addr_reg : s_axi_awaddr;
    assign wr_data = w_hold_reg ? w_data_reg : s_axi_wdata;
    assign wr_strb = w_hold_reg ? w_strb_reg : s_axi_wstrb;
    wire wr_fire;
    assign wr_fire = aw_have && w_have && !s_axi_bvalid;

    // byte-lane merge, used for the system control register only
    // lanes left out by the strobe keep their old contents
    function [31:0] apcl_merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0] strb;
        integer i;
        begin
            apcl_merge = old_v;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    apcl_merge[i*8 +: 8] = new_v[i*8 +: 8];
                end
            end
        end
    endfunction

    // address decode, shared by read and write paths
    // misaligned or out-of-range addresses answer with a slave error
    function apcl_mapped;
        input [4:0] a;
        begin
            apcl_mapped = (a[1:0] == 2'h0) && (a <= `APCL_INTMASK_ADDR);
        end
    endfunction

    wire wr_sys;
    wire wr_ch;
    wire wr_th;
    wire wr_mask;
    assign wr_sys = wr_fire && (wr_addr == {1'b0, `APCL_SYSCTRL_ADDR});
    assign wr_ch = wr_fire && (wr_addr == {1'b0, `APCL_CHREG_ADDR});
    assign wr_th = wr_fire && (wr_addr == {1'b0, `APCL_TEMPTH_ADDR});
    assign wr_mask = wr_fire && (wr_addr == `APCL_INTMASK_ADDR);

    // clear pulse: bit 6 of a channel register write with that lane enabled
    wire temp_clear;
    assign temp_clear = wr_ch && wr_strb[0] && wr_data[`APCL_CLEAR_BIT]; // [R4]

    // read-side accept; reading status clears interrupt bits
    // the word returned is the one cleared, as both happen on one edge
    assign s_axi_arready = !s_axi_rvalid;
    wire rd_fire;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    wire rd_intstat;
    assign rd_intstat = rd_fire && (s_axi_araddr == `APCL_INTSTAT_ADDR);

    // interrupt events: rising edges of the three live alarm kinds
    // only rising edges count, so a standing fault raises one event
    wire [2:0] int_event;
    assign int_event[0] = temp_live && !temp_live_d_reg;
    assign int_event[1] = |(guard_live & ~guard_live_d_reg);
    assign int_event[2] = |(clamp_live & ~clamp_live_d_reg);

    // latched alarm flags: set beats clear in the same cycle
    // a clear that meets a live condition is lost; the host clears again later
    wire temp_latch_next;
    assign temp_latch_next = temp_live | (temp_latch_reg & ~temp_clear); // [R2] [R14]

    // per-channel latched flags for guard and clamp sources
    // one clear write empties every channel of both sources
    genvar ch;
    generate
        for (ch = 0; ch < 4; ch = ch + 1) begin : g_ch
            always @(posedge aclk) begin
                if (!aresetn) begin
                    guard_latch_reg[ch] <= 1'b0;
                    clamp_latch_reg[ch] <= 1'b0;
                end else begin
                    // live set wins over the clear write [R8]
                    guard_latch_reg[ch] <= guard_live[ch] | (guard_latch_reg[ch] & ~temp_clear);
                    clamp_latch_reg[ch] <= clamp_live[ch] | (clamp_latch_reg[ch] & ~temp_clear);
                end
            end
        end
    endgenerate

    // main control registers
    // threshold, channel and mask registers store the low byte lane only
    always @(posedge aclk) begin
        if (!aresetn) begin // [R1]
            sysctrl_reg <= `APCL_SYSCTRL_RESET; // [R5]
            temp_th_reg <= `APCL_TEMP_DEFAULT;
            chreg_reg <= 4'h0;
            temp_latch_reg <= 1'b0;
            int_stat_reg <= 3'h0;
            int_mask_reg <= 3'h0;
            temp_live_d_reg <= 1'b0;
            guard_live_d_reg <= 4'h0;
            clamp_live_d_reg <= 4'h0;
        end else begin
            temp_latch_reg <= temp_latch_next;
            temp_live_d_reg <= temp_live;
            guard_live_d_reg <= guard_live;
            clamp_live_d_reg <= clamp_live;
            if (wr_sys) begin
                sysctrl_reg <= apcl_merge(sysctrl_reg, wr_data, wr_strb); // [R6] [R7] [R12]
            end
            if (wr_th) begin
                temp_th_reg <= wr_strb[0] ? wr_data[7:0] : temp_th_reg;
            end
            if (wr_ch) begin
                chreg_reg <= wr_strb[0] ? wr_data[3:0] : chreg_reg;
            end
            if (wr_mask) begin
                int_mask_reg <= wr_strb[0] ? wr_data[2:0] : int_mask_reg;
            end
            // new events survive a clearing read
            int_stat_reg <= (rd_intstat ? 3'h0 : int_stat_reg) | int_event;
        end
    end

    // write channel holding and response
    // an address or data beat that arrives alone waits here for its partner
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            aw_addr_reg <= 5'h00;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            if (wr_fire) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= apcl_mapped(wr_addr) ? 2'h0 : 2'h2;
            end else begin
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_hold_reg <= 1'b1;
                    aw_addr_reg <= s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_hold_reg <= 1'b1;
                    w_data_reg <= s_axi_wdata;
                    w_strb_reg <= s_axi_wstrb;
                end
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
        end
    end

    // alarm status word: live and latched flags per channel and source
    // read only; a write to it answers OKAY and changes nothing
    wire [31:0] alm_status;
    assign alm_status = {14'h0000, temp_live, temp_latch_reg,
                         clamp_live, clamp_latch_reg, guard_live, guard_latch_reg}; // [R3] [R8]

    // read data path
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= apcl_mapped(s_axi_araddr) ? 2'h0 : 2'h2;
            case (s_axi_araddr)
                {1'b0, `APCL_SYSCTRL_ADDR}: s_axi_rdata <= sysctrl_reg;
                {1'b0, `APCL_CHREG_ADDR}: s_axi_rdata <= {28'h0000000, chreg_reg};
                {1'b0, `APCL_TEMPTH_ADDR}: s_axi_rdata <= {24'h000000, temp_th_reg};
                {1'b0, `APCL_ALMSTAT_ADDR}: s_axi_rdata <= alm_status;
                `APCL_INTSTAT_ADDR: s_axi_rdata <= {29'h00000000, int_stat_reg};
                `APCL_INTMASK_ADDR: s_axi_rdata <= {29'h00000000, int_mask_reg};
                default: s_axi_rdata <= 32'h00000000;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // guard/clamp alarm: sources gated per enable, then latched or live
    wire cg_live;
    wire cg_latched;
    wire cg_assert;
    assign cg_live = (sysctrl_reg[`APCL_SYS_GUARDEN] & (|guard_live))
                   | (sysctrl_reg[`APCL_SYS_CLAMPEN] & (|clamp_live)); // [R7]
    assign cg_latched = (sysctrl_reg[`APCL_SYS_GUARDEN] & (|guard_latch_reg))
                      | (sysctrl_reg[`APCL_SYS_CLAMPEN] & (|clamp_latch_reg)); // [R7]
    assign cg_assert = sysctrl_reg[`APCL_SYS_CGEN]
                     & (sysctrl_reg[`APCL_SYS_CGLATCH] ? cg_latched : cg_live); // [R5] [R6] [R14]

    // registered so that a glitch among the enable terms never reaches the pin
    always @(posedge aclk) begin
        if (!aresetn) begin
            cg_oe_n_reg <= 1'h1; // [R5]
        end else begin
            cg_oe_n_reg <= ~cg_assert; // [R6]
        end
    end

    // open drain: output always low, enable low means pulling the pin low
    // the pin is never driven high; the board pull-up supplies that level
    assign overtemp_alarm_n_o = 1'b0;
    assign overtemp_alarm_n_oe_n = ~temp_latch_reg; // [R2]
    assign guard_clamp_alarm_n_o = 1'b0;
    assign guard_clamp_alarm_n_oe_n = cg_oe_n_reg;

    // pin function selection from interface pin and per-channel config
    // the mode follows the pin level outside reset; nothing latches it at reset
    always @(posedge aclk) begin
        if (!aresetn) begin
            lvds_mode <= 1'b0;
            comparator_pins_as_lvds <= 4'h0;
            guard_or_low_sense_sel <= 4'h0; // [R13]
            guard_amp_from_high_sense <= 4'h0;
            shared_low_sense_in_use <= 1'b1; // [R11]
        end else begin
            lvds_mode <= iface_s; // [R9]
            comparator_pins_as_lvds <= {4{iface_s}}; // [R10]
            guard_or_low_sense_sel <= sysctrl_reg[`APCL_SYS_LSENSE_LSB +: 4]; // [R12]
            guard_amp_from_high_sense <= sysctrl_reg[`APCL_SYS_LSENSE_LSB +: 4]; // [R13]
            shared_low_sense_in_use <= ~&sysctrl_reg[`APCL_SYS_LSENSE_LSB +: 4]; // [R11]
        end
    end

    // level interrupt from unmasked sticky bits
    // the mask gates only the output; status bits still gather events
    assign irq = |(int_stat_reg & int_mask_reg);
endmodule

/* File: verif/apcl_properties.sv */
// port-level checker for the alarm and pin config logic
`timescale 1ns/1ps
module apcl_properties (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [7:0] junction_temp,
    input wire logic [3:0] guard_fault,
    input wire logic iface_select,
    input wire logic overtemp_alarm_n_oe_n,
    input wire logic guard_clamp_alarm_n_oe_n,
    input wire logic lvds_mode,
    input wire logic [3:0] comparator_pins_as_lvds,
    input wire logic [3:0] guard_or_low_sense_sel,
    input wire logic [3:0] guard_amp_from_high_sense,
    input wire logic shared_low_sense_in_use,
    input wire logic irq
);
    logic [8:0] sys_reg;
    // shadow of the control word; full-word writes only, as the bench does
    always @(posedge aclk) begin
        if (!aresetn) begin
            sys_reg <= 9'h000;
        end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                     && s_axi_awaddr == 5'h00 && s_axi_wstrb == 4'hF) begin
            sys_reg <= s_axi_wdata[8:0];
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // six samples cover the two-flop synchroniser, the agreement filter and the flag
    sequence hot_held;
        (!sys_reg[8] && junction_temp > 8'h82) [*6];
    endsequence
    sequence guard_held;
        (sys_reg[3:0] == 4'h5 && guard_fault != 4'h0) [*6];
    endsequence
    sequence select_held;
        $stable(iface_select) [*5];
    endsequence
    a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=>
        overtemp_alarm_n_oe_n && guard_clamp_alarm_n_oe_n && !irq && shared_low_sense_in_use)
        else $error("outputs not at reset values");
    a_temp_hot: assert property (hot_held |-> !overtemp_alarm_n_oe_n)
        else $error("overtemp alarm not driven");
    a_temp_hold: assert property (!overtemp_alarm_n_oe_n && !s_axi_wvalid
        |=> !overtemp_alarm_n_oe_n)
        else $error("overtemp alarm released without clear");
    a_cg_off: assert property (!sys_reg[0] && !$past(sys_reg[0])
        |-> guard_clamp_alarm_n_oe_n)
        else $error("guard clamp alarm while disabled");
    a_guard_source: assert property (guard_held |-> !guard_clamp_alarm_n_oe_n)
        else $error("guard fault not on shared alarm");
    a_iface_follow: assert property (select_held |-> lvds_mode == iface_select)
        else $error("interface mode does not follow select");
    a_comp_lvds: assert property (comparator_pins_as_lvds == {4{lvds_mode}})
        else $error("comparator pins not matching mode");
    a_shared_sense: assert property (shared_low_sense_in_use
        == !(&guard_or_low_sense_sel))
        else $error("shared low sense use wrong");
    a_sense_select: assert property (guard_or_low_sense_sel == $past(sys_reg[7:4]))
        else $error("low sense select not from control word");
    a_guard_amp: assert property (guard_amp_from_high_sense
        == guard_or_low_sense_sel)
        else $error("guard amp input not following pin use");
endmodule
bind apcl_top apcl_properties u_props (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .junction_temp, .guard_fault, .iface_select, .overtemp_alarm_n_oe_n,
    .guard_clamp_alarm_n_oe_n, .lvds_mode, .comparator_pins_as_lvds, .guard_or_low_sense_sel,
    .guard_amp_from_high_sense, .shared_low_sense_in_use, .irq);

/* File: verif/apcl_pins.sv */
// board-level pins seen by the host: alarm pull-ups and select pull-down
`timescale 1ns/1ps
module apcl_pins (
    input wire logic ot_o,
    input wire logic ot_oe_n,
    input wire logic cg_o,
    input wire logic cg_oe_n,
    input wire logic sel_en,
    input wire logic sel_val,
    output wire logic tmp_pin,
    output wire logic cg_pin,
    output wire logic iface_select
);
    // released open-drain alarms float up to the pull-up
    assign tmp_pin = ot_oe_n ? 1'h1 : ot_o;
    assign cg_pin = cg_oe_n ? 1'h1 : cg_o;
    // undriven select falls to the pull-down
    assign iface_select = sel_en ? sel_val : 1'h0;
endmodule

/* File: verif/apcl_top_tb.sv */
// self-checking bench for the alarm and pin config logic
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module apcl_top_tb;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [4:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, rd;
    logic [3:0] s_axi_wstrb, guard_fault, clamp_fault;
    logic [7:0] junction_temp;
    logic [1:0] rs;
    logic sel_en, sel_val;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, iface_select;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire overtemp_alarm_n_o, overtemp_alarm_n_oe_n, guard_clamp_alarm_n_o, tmp_pin, cg_pin;
    wire guard_clamp_alarm_n_oe_n, lvds_mode, shared_low_sense_in_use, irq;
    wire [3:0] comparator_pins_as_lvds, guard_or_low_sense_sel, guard_amp_from_high_sense;
    int n_errors, n_tests, cyc;
    apcl_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .junction_temp, .guard_fault, .clamp_fault,
        .iface_select, .overtemp_alarm_n_o, .overtemp_alarm_n_oe_n, .guard_clamp_alarm_n_o,
        .guard_clamp_alarm_n_oe_n, .lvds_mode, .comparator_pins_as_lvds,
        .guard_or_low_sense_sel, .guard_amp_from_high_sense, .shared_low_sense_in_use, .irq);
    apcl_pins u_pins (.ot_o(overtemp_alarm_n_o), .ot_oe_n(overtemp_alarm_n_oe_n),
        .cg_o(guard_clamp_alarm_n_o), .cg_oe_n(guard_clamp_alarm_n_oe_n), .sel_en, .sel_val,
        .tmp_pin, .cg_pin, .iface_select);
    initial begin
        aclk = 1'h0;
        forever #20 aclk = ~aclk;
    end
    task test_done;
        if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // run is well under a thousand cycles; this only cuts a hang
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            test_done();
        end
    end
    task tick(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // each channel released at the edge that takes it; bready held until bvalid
    task wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        rs = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task rchk(input logic [4:0] a, input logic [31:0] e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'h0;
        `CHK(rd, e)
    endtask
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, clamp_fault, sel_en, sel_val} = 48'h0;
        s_axi_wstrb = 4'hF;
        guard_fault = 4'hF;
        junction_temp = 8'h19;
        tick(16);
        aresetn <= 1'h1;
        tick(8);
        // faults already live but the shared alarm stays off
        `CHK(cg_pin, 1'h1)
        `CHK(shared_low_sense_in_use, 1'h1)
        `CHK(lvds_mode, 1'h0)
        rchk(5'h08, 32'h00000082);
        rchk(5'h00, 32'h00000000);
        rchk(5'h18, 32'h00000000);
        `CHK(rs, 2'h2)
        wr(5'h18, 32'hFFFFFFFF);
        `CHK(rs, 2'h2)
        rchk(5'h0C, 32'h000000FF);
        guard_fault <= 4'h0;
        tick(6);
        rchk(5'h0C, 32'h0000000F);
        wr(5'h04, 32'h00000040);
        rchk(5'h0C, 32'h00000000);
        `CHK(irq, 1'h0)
        rchk(5'h10, 32'h00000002);
        // mode select driven high, then released to the pull-down
        sel_en <= 1'h1;
        sel_val <= 1'h1;
        tick(6);
        `CHK(lvds_mode, 1'h1)
        `CHK(comparator_pins_as_lvds, 4'hF)
        sel_en <= 1'h0;
        tick(6);
        `CHK(lvds_mode, 1'h0)
        wr(5'h00, 32'h000000F0);
        tick(2);
        `CHK(guard_or_low_sense_sel, 4'hF)
        `CHK(guard_amp_from_high_sense, 4'hF)
        `CHK(shared_low_sense_in_use, 1'h0)
        wr(5'h00, 32'h00000070);
        tick(2);
        `CHK(shared_low_sense_in_use, 1'h1)
        // temperature alarm with interrupt unmasked; 130 itself is not above
        wr(5'h14, 32'h00000001);
        junction_temp <= 8'h83;
        tick(6);
        `CHK(tmp_pin, 1'h0)
        `CHK(irq, 1'h1)
        rchk(5'h0C, 32'h00030000);
        rchk(5'h10, 32'h00000001);
        tick(1);
        `CHK(irq, 1'h0)
        rchk(5'h10, 32'h00000000);
        junction_temp <= 8'h82;
        tick(6);
        rchk(5'h0C, 32'h00010000);
        `CHK(tmp_pin, 1'h0)
        wr(5'h04, 32'h00000040);
        tick(1);
        `CHK(tmp_pin, 1'h1)
        // programmed threshold, interrupt masked
        wr(5'h14, 32'h00000000);
        wr(5'h08, 32'h00000064);
        wr(5'h00, 32'h00000100);
        junction_temp <= 8'h65;
        tick(6);
        `CHK(tmp_pin, 1'h0)
        `CHK(irq, 1'h0)
        rchk(5'h10, 32'h00000001);
        junction_temp <= 8'h19;
        tick(6);
        wr(5'h04, 32'h00000040);
        // shared alarm, unlatched guard source only, then latched clamp source only
        wr(5'h00, 32'h00000005);
        clamp_fault <= 4'h2;
        tick(6);
        `CHK(cg_pin, 1'h1)
        guard_fault <= 4'h1;
        tick(6);
        `CHK(cg_pin, 1'h0)
        rchk(5'h0C, 32'h00002211);
        guard_fault <= 4'h0;
        tick(6);
        `CHK(cg_pin, 1'h1)
        wr(5'h00, 32'h0000000B);
        tick(6);
        `CHK(cg_pin, 1'h0)
        clamp_fault <= 4'h0;
        tick(6);
        `CHK(cg_pin, 1'h0)
        wr(5'h04, 32'h00000040);
        tick(2);
        `CHK(cg_pin, 1'h1)
        // guard and clamp rises since the last read, none for temperature
        rchk(5'h10, 32'h00000006);
        // second reset in mid-run restores the reset values, not the programmed ones
        aresetn <= 1'h0;
        tick(2);
        aresetn <= 1'h1;
        tick(2);
        rchk(5'h08, 32'h00000082);
        rchk(5'h00, 32'h00000000);
        test_done();
    end
endmodule
